// File: hdl/disk_addr_cfg.svh
/*
 * constants for the sector address register: digit counts, fold threshold,
 * character zone codes. assumes nothing beyond being included by bare name.
 */
`ifndef DISK_ADDR_CFG_SVH
`define DISK_ADDR_CFG_SVH

`define ADDR_DIGITS    5             // five decimal digits per sector address
`define SECTOR_COUNT   50000         // linear sectors in the store
`define SECTOR_CHARS   100           // characters held by one sector
`define HI_DIGIT       4             // index of the most significant digit
`define FOLD_LIMIT     4'h4          // largest legal high-order digit
`define FOLD_STEP      4'h5          // amount taken off a high digit above limit
`define BCD_MAX        4'h9          // largest decimal digit
`define ZONE_NONE      2'h0          // purely numeric character
`define ZONE_MINUS     2'h2          // zone that marks a negative units digit

`endif

// File: hdl/disk_addr_pkg.sv
/*
 * types for the sector address register.
 * assumes disk_addr_cfg.svh is on the include path.
 */
`include "disk_addr_cfg.svh"

package disk_addr_pkg;
	typedef logic [`ADDR_DIGITS-1:0][3:0] addr_t;   // packed decimal address, digit 4 high

	typedef struct packed {
		logic [1:0] zone;                           // zone punch part
		logic [3:0] num;                            // numeric part
	} char_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,                            // no sector obtained yet
		ST_SEEK = 2'b01,                            // arm moving to addressed sector
		ST_HOLD = 2'b10                             // sector obtained
	} arm_state_t;
endpackage

// File: hdl/disk_address_register_fold.sv
/*
 * sector address register with high-digit fold, record advance and
 * accumulator character stripping for a decimal disk store.
 * assumes one clock, program-side inputs synchronous to it, and an arm
 * mechanism that answers each seek pulse with sector_found.
 */
// Contract
// - store is a linear set of 50000 sectors of 100 characters, one address each
// - only five-digit decimal addresses 00000 to 49999 are valid
// - loading an address whose high digit exceeds 4 takes 5 off that digit
// - record advance after a sector is obtained fetches address plus one
// - an alphabetic character entering an accumulator keeps only its numeric part
// - an alphabetic units character may mark the operand for subtraction
`include "disk_addr_cfg.svh"

module disk_address_register_fold (
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	input  wire logic                 load_valid,
	input  wire disk_addr_pkg::addr_t load_digits,
	input  wire logic                 advance_req,
	input  wire logic                 sector_found,
	input  wire logic                 char_valid,
	input  wire disk_addr_pkg::char_t char_in,
	input  wire logic                 char_units,
	output disk_addr_pkg::addr_t      addr_ff,
	output logic                      seek_ff,
	output logic                      ready_ff,
	output logic                      addr_err_ff,
	output logic [3:0]                digit_ff,
	output logic                      digit_valid_ff,
	output logic                      sub_ff
);

	disk_addr_pkg::arm_state_t state_ff;
	disk_addr_pkg::arm_state_t nxt_state;
	disk_addr_pkg::addr_t      nxt_addr;
	logic [`ADDR_DIGITS-1:0]   digit_bad;
	logic                      take_load;
	logic                      take_adv;

	// fold the high-order digit back into range, lower digits pass
	function automatic disk_addr_pkg::addr_t fold(input disk_addr_pkg::addr_t a);
		disk_addr_pkg::addr_t r;
		r = a;
		if (a[`HI_DIGIT] > `FOLD_LIMIT) begin
			r[`HI_DIGIT] = a[`HI_DIGIT] - `FOLD_STEP;
		end
		return r;
	endfunction

	// decimal increment with carry through all five digits
	function automatic disk_addr_pkg::addr_t bcd_inc(input disk_addr_pkg::addr_t a);
		disk_addr_pkg::addr_t r;
		logic                 c;
		r = a;
		c = 1'b1;
		for (int i = 0; i < `ADDR_DIGITS; i++) begin
			if (c) begin
				if (a[i] == `BCD_MAX) begin
					r[i] = 4'h0;
				end else begin
					r[i] = a[i] + 4'h1;
					c    = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// flag any loaded nibble that is not a decimal digit
	for (genvar g = 0; g < `ADDR_DIGITS; g++) begin : g_chk
		assign digit_bad[g] = load_digits[g] > `BCD_MAX;
	end

	// loads are refused while the arm is moving, advance only once a sector is held
	assign take_load = load_valid && (state_ff != disk_addr_pkg::ST_SEEK);
	assign take_adv  = advance_req && !load_valid && (state_ff == disk_addr_pkg::ST_HOLD);

	// next address: folded load, or folded successor so 49999 wraps to 00000
	always_comb begin
		nxt_addr = addr_ff;
		if (take_load) begin
			nxt_addr = fold(load_digits);
		end else if (take_adv) begin
			nxt_addr = fold(bcd_inc(addr_ff));
		end
	end

	// arm sequencing
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			disk_addr_pkg::ST_IDLE: begin
				if (take_load) nxt_state = disk_addr_pkg::ST_SEEK;
			end
			disk_addr_pkg::ST_SEEK: begin
				if (sector_found) nxt_state = disk_addr_pkg::ST_HOLD;
			end
			disk_addr_pkg::ST_HOLD: begin
				if (take_load || take_adv) nxt_state = disk_addr_pkg::ST_SEEK;
			end
			default: nxt_state = disk_addr_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) state_ff <= disk_addr_pkg::ST_IDLE;
		else       state_ff <= nxt_state;
	end

	// address register
	always_ff @(posedge sys_clk) begin
		if (!rstn) addr_ff <= '0;
		else       addr_ff <= nxt_addr;
	end

	// one-cycle seek request whenever a new address is taken
	always_ff @(posedge sys_clk) begin
		if (!rstn) seek_ff <= 1'b0;
		else       seek_ff <= take_load || take_adv;
	end

	// ready mirrors whether a load would be taken next cycle
	always_ff @(posedge sys_clk) begin
		if (!rstn) ready_ff <= 1'b1;
		else       ready_ff <= (nxt_state != disk_addr_pkg::ST_SEEK);
	end

	// sticky until the next accepted load: set if any loaded digit is not decimal
	always_ff @(posedge sys_clk) begin
		if (!rstn)          addr_err_ff <= 1'b0;
		else if (take_load) addr_err_ff <= |digit_bad;
	end

	// accumulator entry: zone dropped, units zone may call for subtraction
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			digit_ff       <= 4'h0;
			digit_valid_ff <= 1'b0;
			sub_ff         <= 1'b0;
		end else begin
			digit_valid_ff <= char_valid;
			if (char_valid) begin
				digit_ff <= char_in.num;
				sub_ff   <= char_units && (char_in.zone == `ZONE_MINUS);
			end
		end
	end

	// helper history for the checks below
	disk_addr_pkg::addr_t prev_ld_ff;
	disk_addr_pkg::addr_t prev_addr_ff;
	disk_addr_pkg::char_t prev_char_ff;

	always_ff @(posedge sys_clk) begin
		prev_ld_ff   <= load_digits;
		prev_addr_ff <= addr_ff;
		prev_char_ff <= char_in;
	end

	// checks on fold, refusal, advance and accumulator entry, all in the one clock domain
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	high_fold_a: assert property (
		take_load && load_digits[`HI_DIGIT] > `FOLD_LIMIT && !digit_bad[`HI_DIGIT]
		|=> addr_ff[`HI_DIGIT] == prev_ld_ff[`HI_DIGIT] - `FOLD_STEP)
		else $error("high digit not folded by five");

	low_digits_kept_a: assert property (
		take_load |=> addr_ff[`HI_DIGIT-1:0] == prev_ld_ff[`HI_DIGIT-1:0])
		else $error("lower address digits altered on load");

	addr_in_range_a: assert property (
		!addr_err_ff |-> addr_ff[`HI_DIGIT] <= `FOLD_LIMIT)
		else $error("address above 49999");

	advance_step_a: assert property (
		take_adv |=> addr_ff == fold(bcd_inc(prev_addr_ff)) && seek_ff)
		else $error("advance did not fetch next sector");

	advance_gated_a: assert property (
		advance_req && state_ff != disk_addr_pkg::ST_HOLD && !take_load |=> $stable(addr_ff) && !seek_ff)
		else $error("advance taken before sector obtained");

	wrap_top_a: assert property (
		take_adv && addr_ff == 20'h49999 |=> addr_ff == '0)
		else $error("last sector did not wrap to first");

	zone_strip_a: assert property (
		char_valid |=> digit_valid_ff && digit_ff == prev_char_ff.num)
		else $error("zone part reached accumulator");

	units_sign_a: assert property (
		char_valid |=> sub_ff == (prev_char_ff.zone == `ZONE_MINUS && $past(char_units)))
		else $error("units sign not honoured");

	seek_pulse_a: assert property (
		seek_ff |=> !seek_ff ##0 state_ff == disk_addr_pkg::ST_SEEK || sector_found)
		else $error("seek request longer than one cycle");

	load_refused_a: assert property (
		load_valid && state_ff == disk_addr_pkg::ST_SEEK |=> $stable(addr_ff) && !seek_ff)
		else $error("load taken while arm was moving");

	load_seeks_a: assert property (
		take_load |=> seek_ff && !ready_ff && state_ff == disk_addr_pkg::ST_SEEK)
		else $error("taken load did not start a seek");

	units_step_a: assert property (
		take_adv && !addr_err_ff && addr_ff[0] != `BCD_MAX
		|=> addr_ff[0] == prev_addr_ff[0] + 4'h1 && addr_ff[`HI_DIGIT:1] == prev_addr_ff[`HI_DIGIT:1])
		else $error("advance did not step the units digit");

	// main scenarios reached
	fold_load_c:  cover property (take_load && load_digits[`HI_DIGIT] > `FOLD_LIMIT);
	carry_adv_c:  cover property (take_adv && addr_ff[0] == `BCD_MAX ##1 seek_ff);
	sign_units_c: cover property (char_valid && char_units && char_in.zone == `ZONE_MINUS);
	wrap_adv_c:   cover property (take_adv && addr_ff == 20'h49999);
	refuse_ld_c:  cover property (load_valid && state_ff == disk_addr_pkg::ST_SEEK);

endmodule // disk_address_register_fold

// File: test/arm_model.sv
/*
 * arm positioning model: answers each seek pulse with one found pulse
 * after a travel time set by the bench. assumes seek is one cycle wide.
 */
module arm_model (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       seek,
	input  wire logic [7:0] delay,
	output logic            found_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_ff;
	logic       busy_ff;
	// count out the travel time, then report the sector for one cycle
	always_ff @(posedge sys_clk) begin
		found_ff <= 1'b0;
		if (!rstn) begin
			busy_ff <= 1'b0;
			cnt_ff  <= 8'h00;
		end else if (seek) begin
			busy_ff <= 1'b1; // one sector address per seek
			cnt_ff  <= delay;
		end else if (busy_ff) begin
			if (cnt_ff == 8'h00) begin
				busy_ff  <= 1'b0;
				found_ff <= 1'b1;
			end else
				cnt_ff <= cnt_ff - 8'h01;
		end
	end
endmodule // arm_model

// File: test/disk_address_register_fold_tb.sv
/*
 * bench for the sector address register: fold, refusal, advance, chars.
 * assumes the arm model answers seeks; all inputs driven at rising edges.
 */
module disk_address_register_fold_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, rstn = 1'b0, load_valid = 1'b0, advance_req = 1'b0;
	logic char_valid = 1'b0, char_units = 1'b0, sector_found, seek_ff, ready_ff;
	logic addr_err_ff, digit_valid_ff, sub_ff;
	logic [3:0] digit_ff;
	logic [7:0] delay = 8'h00;
	disk_addr_pkg::addr_t load_digits = 20'h00000, addr_ff;
	disk_addr_pkg::char_t char_in = 6'h00;
	int n_errors = 0, n_tests = 0;

	always #2 sys_clk = ~sys_clk;

	disk_address_register_fold DUT (.sys_clk(sys_clk), .rstn(rstn), .load_valid(load_valid),
		.load_digits(load_digits), .advance_req(advance_req), .sector_found(sector_found),
		.char_valid(char_valid), .char_in(char_in), .char_units(char_units), .addr_ff(addr_ff),
		.seek_ff(seek_ff), .ready_ff(ready_ff), .addr_err_ff(addr_err_ff), .digit_ff(digit_ff),
		.digit_valid_ff(digit_valid_ff), .sub_ff(sub_ff));
	arm_model arm (.sys_clk(sys_clk), .rstn(rstn), .seek(seek_ff), .delay(delay),
		.found_ff(sector_found));

	task automatic results;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// compare a multi-digit value and a single flag
	task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	// bounded wait until the arm reports and ready shows a new load would be taken
	task automatic wait_ready;
		for (int i = 0; i < 300; i++) begin
			@(posedge sys_clk);
			#1;
			if (ready_ff === 1'b1) return;
		end
		n_errors++;
		$display("ERROR %0t ready never returned", $time);
		results();
	endtask
	// offer one address and check what the register makes of it
	task automatic do_load(input logic [19:0] d, input logic [19:0] exp, input logic err);
		@(posedge sys_clk);
		load_valid  <= 1'b1;
		load_digits <= d;
		@(posedge sys_clk);
		load_valid <= 1'b0;
		#1;
		chk_val(addr_ff, exp);
		chk_bit(seek_ff, 1'b1);
		chk_bit(addr_err_ff, err);
		wait_ready();
	endtask
	task automatic do_advance(input logic [19:0] exp);
		@(posedge sys_clk);
		advance_req <= 1'b1;
		@(posedge sys_clk);
		advance_req <= 1'b0;
		#1;
		chk_val(addr_ff, exp);
		chk_bit(seek_ff, 1'b1);
		wait_ready();
	endtask
	task automatic do_char(input logic [5:0] c, input logic u, input logic [3:0] d, input logic s);
		@(posedge sys_clk);
		char_valid <= 1'b1;
		char_in    <= c;
		char_units <= u;
		@(posedge sys_clk);
		char_valid <= 1'b0;
		#1;
		chk_val({16'h0000, digit_ff}, {16'h0000, d});
		chk_bit(digit_valid_ff, 1'b1);
		chk_bit(sub_ff, s);
	endtask

	// reset values, then an advance in idle must be ignored
	task automatic t_reset;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		chk_val(addr_ff, 20'h00000);
		chk_bit(ready_ff, 1'b1);
		@(posedge sys_clk);
		advance_req <= 1'b1;
		@(posedge sys_clk);
		advance_req <= 1'b0;
		#1;
		chk_bit(seek_ff, 1'b0);
		chk_val(addr_ff, 20'h00000);
		$display("test reset done");
	endtask
	// fold table: only the high digit above 4 loses 5, at both boundaries
	task automatic t_fold;
		do_load(20'h73560, 20'h23560, 1'b0);
		do_load(20'h04152, 20'h04152, 1'b0);
		do_load(20'h49999, 20'h49999, 1'b0);
		do_load(20'h50000, 20'h00000, 1'b0);
		do_load(20'h99999, 20'h49999, 1'b0);
		do_load(20'h4a000, 20'h4a000, 1'b1);
		$display("test fold done");
	endtask
	// slow arm: a load held on into the seek is refused; a load beats an advance
	task automatic t_refuse;
		@(posedge sys_clk);
		delay       <= 8'h14;
		load_valid  <= 1'b1;
		load_digits <= 20'h12345;
		@(posedge sys_clk);
		load_digits <= 20'h31111;
		#1;
		chk_val(addr_ff, 20'h12345);
		chk_bit(addr_err_ff, 1'b0);
		@(posedge sys_clk);
		load_valid <= 1'b0;
		#1;
		chk_val(addr_ff, 20'h12345);
		chk_bit(seek_ff, 1'b0);
		chk_bit(ready_ff, 1'b0);
		wait_ready();
		chk_val(addr_ff, 20'h12345);
		@(posedge sys_clk);
		delay       <= 8'h00;
		load_valid  <= 1'b1;
		advance_req <= 1'b1;
		load_digits <= 20'h61111;
		@(posedge sys_clk);
		load_valid  <= 1'b0;
		advance_req <= 1'b0;
		#1;
		chk_val(addr_ff, 20'h11111);
		chk_bit(seek_ff, 1'b1);
		wait_ready();
		$display("test refuse done");
	endtask
	// advance from an even sector and across the top of the store
	task automatic t_advance;
		do_load(20'h46866, 20'h46866, 1'b0);
		do_advance(20'h46867);
		do_load(20'h10099, 20'h10099, 1'b0);
		do_advance(20'h10100);
		do_load(20'h49999, 20'h49999, 1'b0);
		do_advance(20'h00000);
		$display("test advance done");
	endtask
	task automatic t_char;
		do_char(6'h13, 1'b0, 4'h3, 1'b0);
		do_char(6'h24, 1'b1, 4'h4, 1'b1);
		do_char(6'h27, 1'b0, 4'h7, 1'b0);
		do_char(6'h09, 1'b1, 4'h9, 1'b0);
		do_char(6'h35, 1'b1, 4'h5, 1'b0);
		$display("test char done");
	endtask

	initial begin
		t_reset();
		t_fold();
		t_refuse();
		t_advance();
		t_char();
		results();
	end
endmodule // disk_address_register_fold_tb
